// file: common/hcc_pkg.sv
package hcc_pkg;

  // time base
  localparam int unsigned CLK_PERIOD_NS     = 50;

  // off-time figures
  localparam int unsigned OFF_INT_NS        = 20000;
  localparam int unsigned OFF_MIN_NS        = 10000;
  localparam int unsigned OFF_MAX_NS        = 80000;
  localparam int unsigned KTOFF_NS_PER_KOHM = 667;
  localparam int unsigned OFF_INT_CYC       = OFF_INT_NS / CLK_PERIOD_NS;
  localparam int unsigned OFF_MIN_CYC       = (OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OFF_MAX_CYC       = OFF_MAX_NS / CLK_PERIOD_NS;

  // protection and wake timing
  localparam int unsigned RETRY_NS          = 3000000;
  localparam int unsigned RETRY_CYC         = RETRY_NS / CLK_PERIOD_NS;
  localparam int unsigned WAKE_NS           = 2700000;
  localparam int unsigned WAKE_CYC          = WAKE_NS / CLK_PERIOD_NS;
  localparam int unsigned BLANK_NS          = 1000;
  localparam int unsigned BLANK_CYC         = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // mixed decay split, slow share in percent
  localparam int unsigned PCT_FULL          = 100;
  localparam int unsigned SLOW_PCT_MIX30    = 70;
  localparam int unsigned SLOW_PCT_MIX60    = 40;

  // widths
  localparam int unsigned TW                = 16;
  localparam int unsigned RW                = 20;
  localparam int unsigned KW                = 8;
  localparam int unsigned AW                = 8;
  localparam int unsigned DW                = 32;

  // register map
  localparam logic [AW-1:0] ADR_CFG         = 8'h00;
  localparam logic [AW-1:0] ADR_THR_A       = 8'h04;
  localparam logic [AW-1:0] ADR_THR_B       = 8'h08;
  localparam logic [AW-1:0] ADR_STATUS      = 8'h0c;

  // cfg fields and reset values
  localparam int unsigned   CFG_INT_BIT     = 0;
  localparam int unsigned   CFG_KOHM_LSB    = 8;
  localparam logic          CFG_INT_RST     = 1'b1;
  localparam logic [KW-1:0] CFG_KOHM_RST    = 8'h1e;
  localparam logic [KW-1:0] THR_RST         = 8'h18;

  // status fields
  localparam int unsigned ST_RETRY_A        = 0;
  localparam int unsigned ST_RETRY_B        = 1;
  localparam int unsigned ST_OVER_TEMP      = 2;
  localparam int unsigned ST_VM_UV          = 3;
  localparam int unsigned ST_REG_PIN_A      = 4;
  localparam int unsigned ST_REG_PIN_B      = 5;
  localparam int unsigned ST_AWAKE          = 6;
  localparam int unsigned ST_FAULT_PIN      = 7;

  typedef enum logic [1:0] {
    DEC_SLOW  = 2'b00,
    DEC_MIX30 = 2'b01,
    DEC_MIX60 = 2'b10,
    DEC_FAST  = 2'b11
  } hcc_decay_t;

  typedef enum logic [1:0] {
    BS_DRIVE = 2'b00,
    BS_FAST  = 2'b01,
    BS_SLOW  = 2'b10,
    BS_RETRY = 2'b11
  } hcc_bst_t;

endpackage : hcc_pkg

// file: common/hcc_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface hcc_tmr_if #(parameter int unsigned W = 16);
  logic         load;
  logic [W-1:0] load_val;
  logic [W-1:0] remaining;
  logic         expire;
  modport ctl (output load, output load_val, input remaining, input expire);
  modport tmr (input load, input load_val, output remaining, output expire);
endinterface : hcc_tmr_if
`default_nettype wire

// file: core/hcc_timer.sv
`timescale 1ns/10ps
`default_nettype none
module hcc_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic ce,
  hcc_tmr_if.tmr    t
);
  // load wins over counting so a restart never loses a cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      t.remaining <= '0;
      t.expire    <= 1'b0;
    end else if (ce) begin
      t.expire <= 1'b0;
      if (t.load) begin
        t.remaining <= t.load_val;
      end else if (t.remaining != '0) begin
        t.remaining <= t.remaining - W'(1);
        t.expire    <= (t.remaining == W'(1));
      end
    end
  end
endmodule : hcc_timer
`default_nettype wire

// file: core/hcc_blank.sv
`timescale 1ns/10ps
`default_nettype none
module hcc_blank #(
  parameter int unsigned N = 20,
  parameter int unsigned W = 8
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic level,
  output var  logic event_q
);
  localparam logic [W-1:0] N_W = W'(N);
  logic [W-1:0] cnt_q;
  logic         fired_q;

  // one event per excursion; a shorter excursion clears the count
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q   <= '0;
      fired_q <= 1'b0;
      event_q <= 1'b0;
    end else if (ce) begin
      event_q <= 1'b0;
      if (!level) begin
        cnt_q   <= '0;
        fired_q <= 1'b0;
      end else if (cnt_q != N_W) begin
        cnt_q <= cnt_q + W'(1);
      end else if (!fired_q) begin
        event_q <= 1'b1;
        fired_q <= 1'b1;
      end
    end
  end
endmodule : hcc_blank
`default_nettype wire

// file: core/hcc_top.sv
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module hcc_top #(
  parameter int unsigned RETRY_CYCLES = hcc_pkg::RETRY_CYC,
  parameter int unsigned WAKE_CYCLES  = hcc_pkg::WAKE_CYC,
  parameter int unsigned BLANK_CYCLES = hcc_pkg::BLANK_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [hcc_pkg::AW-1:0] wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [hcc_pkg::DW-1:0] wb_dat_i,
  output var  logic [hcc_pkg::DW-1:0] wb_dat_o,
  output var  logic                   wb_ack_o,
  input  wire logic                   sleep_n,
  input  wire logic                   bridge_en_a,
  input  wire logic                   bridge_en_b,
  input  wire logic                   direction_in_first_a,
  input  wire logic                   direction_in_second_a,
  input  wire logic                   direction_in_first_b,
  input  wire logic                   direction_in_second_b,
  input  wire logic                   decay_select_bit0,
  input  wire logic                   decay_select_bit1,
  input  wire logic                   trip_current_a,
  input  wire logic                   trip_current_b,
  input  wire logic                   overcurrent_a,
  input  wire logic                   overcurrent_b,
  input  wire logic                   near_zero_a,
  input  wire logic                   near_zero_b,
  input  wire logic                   over_temp,
  input  wire logic                   vm_undervoltage,
  output var  logic                   out1_a,
  output var  logic                   out1_a_oe,
  output var  logic                   out2_a,
  output var  logic                   out2_a_oe,
  output var  logic                   out1_b,
  output var  logic                   out1_b_oe,
  output var  logic                   out2_b,
  output var  logic                   out2_b_oe,
  input  wire logic                   bridge_a_regulating_n_i,
  output var  logic                   bridge_a_regulating_n_o,
  output var  logic                   bridge_a_regulating_n_oe,
  input  wire logic                   bridge_b_regulating_n_i,
  output var  logic                   bridge_b_regulating_n_o,
  output var  logic                   bridge_b_regulating_n_oe,
  input  wire logic                   fault_n_i,
  output var  logic                   fault_n_o,
  output var  logic                   fault_n_oe,
  output var  logic [hcc_pkg::KW-1:0] threshold_set_a,
  output var  logic [hcc_pkg::KW-1:0] threshold_set_b
);
  import hcc_pkg::*;

  localparam int unsigned NB = 2;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [TW-1:0] off_cycles(input logic internal, input logic [KW-1:0] kohm);
    int unsigned c;
    c = int'(kohm) * KTOFF_NS_PER_KOHM / CLK_PERIOD_NS;
    if (c < OFF_MIN_CYC) c = OFF_MIN_CYC;
    if (c > OFF_MAX_CYC) c = OFF_MAX_CYC;
    if (internal) c = OFF_INT_CYC;
    return TW'(c);
  endfunction : off_cycles

  // remaining count at or below which a mixed off phase turns slow
  function automatic logic [TW-1:0] slow_part(input logic [TW-1:0] off, input hcc_decay_t dec);
    int unsigned p;
    case (dec)
      DEC_SLOW:  p = int'(off);
      DEC_MIX30: p = int'(off) * SLOW_PCT_MIX30 / PCT_FULL;
      DEC_MIX60: p = int'(off) * SLOW_PCT_MIX60 / PCT_FULL;
      default:   p = 0;
    endcase
    return TW'(p);
  endfunction : slow_part

  // {out1, oe1, out2, oe2}
  function automatic logic [3:0] pin_drive(input hcc_bst_t st, input logic ok, input logic en,
                                           input logic d1, input logic d2, input logic zero);
    logic [3:0] r;
    r = 4'h0;
    if (ok && en) begin
      case (st)
        BS_DRIVE: r = {d1, 1'b1, d2, 1'b1};
        BS_SLOW:  r = {1'b0, 1'b1, 1'b0, 1'b1};
        BS_FAST:  r = zero ? 4'h0 : {d2, 1'b1, d1, 1'b1};
        default:  r = 4'h0;
      endcase
    end
    return r;
  endfunction : pin_drive

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  logic          ack_q;
  logic [DW-1:0] dat_q;
  logic          cfg_int_q;
  logic [KW-1:0] cfg_kohm_q;
  logic [KW-1:0] thr_a_q;
  logic [KW-1:0] thr_b_q;
  logic [DW-1:0] status_w;
  logic [DW-1:0] rd_d;
  logic          wb_hit;
  logic          wb_wr;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_wr  = wb_hit & wb_we_i;

  // ack one cycle after the request, dropped the next; unmapped reads zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= wb_hit;
    end
  end

  always_comb begin
    rd_d = '0;
    case (wb_adr_i)
      ADR_CFG: begin
        rd_d[CFG_INT_BIT]                 = cfg_int_q;
        rd_d[CFG_KOHM_LSB +: KW]          = cfg_kohm_q;
      end
      ADR_THR_A:  rd_d[KW-1:0] = thr_a_q;
      ADR_THR_B:  rd_d[KW-1:0] = thr_b_q;
      ADR_STATUS: rd_d = status_w;
      default:    rd_d = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dat_q <= '0;
    end else if (ce && wb_hit) begin
      dat_q <= rd_d;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_int_q  <= CFG_INT_RST;
      cfg_kohm_q <= CFG_KOHM_RST;
    end else if (ce && wb_wr && wb_adr_i == ADR_CFG) begin
      if (wb_sel_i[0]) cfg_int_q <= wb_dat_i[CFG_INT_BIT];
      if (wb_sel_i[1]) cfg_kohm_q <= wb_dat_i[CFG_KOHM_LSB +: KW];
    end
  end

  // per-bridge threshold codes feed the analog comparators
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      thr_a_q <= THR_RST;
      thr_b_q <= THR_RST;
    end else if (ce && wb_wr && wb_sel_i[0]) begin
      if (wb_adr_i == ADR_THR_A) thr_a_q <= wb_dat_i[KW-1:0];
      if (wb_adr_i == ADR_THR_B) thr_b_q <= wb_dat_i[KW-1:0];
    end
  end

  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = dat_q;
  assign threshold_set_a = thr_a_q;
  assign threshold_set_b = thr_b_q;

  ////////////////////////////////////////////////////////////////////////////
  // sleep and wake

  hcc_tmr_if #(.W(RW)) wake_t ();
  logic awake_q;

  // wake counter is held loaded during sleep, so it starts at release
  assign wake_t.load     = ~sleep_n;
  assign wake_t.load_val = RW'(WAKE_CYCLES);

  hcc_timer #(.W(RW)) u_wake (
    .mclk (mclk),
    .nrst (nrst),
    .ce   (ce),
    .t    (wake_t)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      awake_q <= 1'b0;
    end else if (ce) begin
      awake_q <= sleep_n & ~wake_t.load & (wake_t.remaining == '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bridges

  logic          global_ok;
  logic [TW-1:0] off_len;
  logic [TW-1:0] slow_len;
  hcc_decay_t    decay_w;
  logic [NB-1:0] en_w;
  logic [NB-1:0] d1_w;
  logic [NB-1:0] d2_w;
  logic [NB-1:0] trip_w;
  logic [NB-1:0] ocp_w;
  logic [NB-1:0] zero_w;

  // thermal and undervoltage gate both bridges while present
  assign global_ok = awake_q & ~over_temp & ~vm_undervoltage;
  assign off_len   = off_cycles(cfg_int_q, cfg_kohm_q);
  assign decay_w   = hcc_decay_t'({decay_select_bit1, decay_select_bit0});
  assign slow_len  = slow_part(off_len, decay_w);
  assign en_w      = {bridge_en_b, bridge_en_a};
  assign d1_w      = {direction_in_first_b, direction_in_first_a};
  assign d2_w      = {direction_in_second_b, direction_in_second_a};
  assign trip_w    = {trip_current_b, trip_current_a};
  assign ocp_w     = {overcurrent_b, overcurrent_a};
  assign zero_w    = {near_zero_b, near_zero_a};

  for (genvar b = 0; b < NB; b++) begin : br
    hcc_tmr_if #(.W(TW)) off_t ();
    hcc_tmr_if #(.W(RW)) retry_t ();
    hcc_bst_t state_q;
    hcc_bst_t state_d;
    logic     ocp_ev;
    logic     driving;
    logic     pwm_edge;
    logic     start_off;
    logic     in_off;
    logic [1:0] dir_prev_q;
    logic     o1_q;
    logic     oe1_q;
    logic     o2_q;
    logic     oe2_q;
    logic     reg_oe_q;

    // each bridge has its own timers and state
    hcc_timer #(.W(TW)) u_off (
      .mclk (mclk),
      .nrst (nrst),
      .ce   (ce),
      .t    (off_t)
    );

    hcc_timer #(.W(RW)) u_retry (
      .mclk (mclk),
      .nrst (nrst),
      .ce   (ce),
      .t    (retry_t)
    );

    hcc_blank #(.N(BLANK_CYCLES), .W(8)) u_blank (
      .mclk    (mclk),
      .nrst    (nrst),
      .ce      (ce),
      .level   (ocp_w[b] & global_ok),
      .event_q (ocp_ev)
    );

    assign driving   = en_w[b] & (d1_w[b] ^ d2_w[b]);
    assign pwm_edge  = ({d1_w[b], d2_w[b]} != dir_prev_q);
    assign in_off    = (state_q == BS_FAST) || (state_q == BS_SLOW);
    assign start_off = (state_q == BS_DRIVE) && global_ok && !ocp_ev && trip_w[b] && driving;

    // restart on trip or on any direction-input change mid off phase
    assign off_t.load       = start_off | (in_off & pwm_edge);
    assign off_t.load_val   = off_len;
    assign retry_t.load     = ocp_ev & (state_q != BS_RETRY);
    assign retry_t.load_val = RW'(RETRY_CYCLES);

    always_comb begin
      state_d = state_q;
      case (state_q)
        BS_DRIVE: begin
          if (ocp_ev) begin
            state_d = BS_RETRY;
          end else if (start_off) begin
            state_d = (decay_w == DEC_SLOW) ? BS_SLOW : BS_FAST;
          end
        end
        BS_FAST: begin
          if (ocp_ev) begin
            state_d = BS_RETRY;
          end else if (off_t.expire && !off_t.load) begin
            state_d = BS_DRIVE;
          end else if (!off_t.load && off_t.remaining <= slow_len) begin
            state_d = BS_SLOW;
          end
        end
        BS_SLOW: begin
          if (ocp_ev) begin
            state_d = BS_RETRY;
          end else if (off_t.expire && !off_t.load) begin
            state_d = BS_DRIVE;
          end
        end
        BS_RETRY: begin
          if (retry_t.expire) begin
            state_d = BS_DRIVE;
          end
        end
        default: state_d = BS_DRIVE;
      endcase
      // sleep stops everything; a disabled bridge leaves its off phase
      if (!awake_q) begin
        state_d = BS_DRIVE;
      end else if (in_off && (!en_w[b] || !global_ok)) begin
        state_d = BS_DRIVE;
      end
    end

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        state_q <= BS_DRIVE;
      end else if (ce) begin
        state_q <= state_d;
      end
    end

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        dir_prev_q <= 2'b00;
      end else if (ce) begin
        dir_prev_q <= {d1_w[b], d2_w[b]};
      end
    end

    // decay overrides inputs; retry and faults hold high-z
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        {o1_q, oe1_q, o2_q, oe2_q} <= 4'h0;
      end else if (ce) begin
        {o1_q, oe1_q, o2_q, oe2_q} <= pin_drive(state_d, global_ok, en_w[b], d1_w[b], d2_w[b], zero_w[b]);
      end
    end

    // pulled low only for regulation-forced slow decay
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        reg_oe_q <= 1'b0;
      end else if (ce) begin
        reg_oe_q <= (state_d == BS_SLOW);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins, fault and status

  logic fault_oe_q;
  logic any_retry;

  assign any_retry = (br[0].state_q == BS_RETRY) || (br[1].state_q == BS_RETRY);

  // open drain: pulled low during retry, or for a temp or supply fault while awake
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fault_oe_q <= 1'b0;
    end else if (ce) begin
      fault_oe_q <= any_retry | (awake_q & (over_temp | vm_undervoltage));
    end
  end

  always_comb begin
    status_w               = '0;
    status_w[ST_RETRY_A]   = (br[0].state_q == BS_RETRY);
    status_w[ST_RETRY_B]   = (br[1].state_q == BS_RETRY);
    status_w[ST_OVER_TEMP] = over_temp;
    status_w[ST_VM_UV]     = vm_undervoltage;
    status_w[ST_REG_PIN_A] = ~bridge_a_regulating_n_i;
    status_w[ST_REG_PIN_B] = ~bridge_b_regulating_n_i;
    status_w[ST_AWAKE]     = awake_q;
    status_w[ST_FAULT_PIN] = ~fault_n_i;
  end

  assign out1_a                   = br[0].o1_q;
  assign out1_a_oe                = br[0].oe1_q;
  assign out2_a                   = br[0].o2_q;
  assign out2_a_oe                = br[0].oe2_q;
  assign out1_b                   = br[1].o1_q;
  assign out1_b_oe                = br[1].oe1_q;
  assign out2_b                   = br[1].o2_q;
  assign out2_b_oe                = br[1].oe2_q;
  assign bridge_a_regulating_n_o  = 1'b0;
  assign bridge_a_regulating_n_oe = br[0].reg_oe_q;
  assign bridge_b_regulating_n_o  = 1'b0;
  assign bridge_b_regulating_n_oe = br[1].reg_oe_q;
  assign fault_n_o                = 1'b0;
  assign fault_n_oe               = fault_oe_q;

endmodule : hcc_top
`default_nettype wire

// file: sim/hcc_props.sv
`timescale 1ns/10ps
`default_nettype none
module hcc_props #(
  parameter int unsigned BLANK_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sleep_n,
  input wire logic bridge_en_a,
  input wire logic direction_in_first_a,
  input wire logic direction_in_second_a,
  input wire logic decay_select_bit0,
  input wire logic decay_select_bit1,
  input wire logic overcurrent_b,
  input wire logic over_temp,
  input wire logic vm_undervoltage,
  input wire logic out1_a,
  input wire logic out2_a,
  input wire logic out1_a_oe,
  input wire logic out2_a_oe,
  input wire logic out1_b_oe,
  input wire logic out2_b_oe,
  input wire logic bridge_a_regulating_n_oe,
  input wire logic fault_n_oe
);
  logic [7:0] oc_q;
  wire        a_off = !out1_a_oe && !out2_a_oe;
  wire        b_off = !out1_b_oe && !out2_b_oe;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // runs starting while bridge b is off are not counted
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      oc_q <= 8'h00;
    end else if (!overcurrent_b) begin
      oc_q <= 8'h00;
    end else if (oc_q != 8'h00 ? oc_q != 8'hff : !b_off) begin
      oc_q <= oc_q + 8'h01;
    end
  end
  sequence dir_a_moves;
    $changed({direction_in_first_a, direction_in_second_a}) && bridge_en_a && sleep_n;
  endsequence
  sequence supply_bad;
    (over_temp || vm_undervoltage) [*2];
  endsequence
  ////////////////////////////////////////
  chk_dis_hiz: assert property (!bridge_en_a [*2] |-> a_off)
    else $error("bridge a driven while disabled");
  chk_sleep_hiz: assert property (!sleep_n [*3] |-> a_off && b_off)
    else $error("outputs driven in sleep");
  chk_supply_hiz: assert property (supply_bad |-> a_off && b_off)
    else $error("outputs driven during temp or supply fault");
  chk_reg_slow: assert property (bridge_a_regulating_n_oe |-> !a_off && !out1_a && !out2_a)
    else $error("regulating flag without slow decay");
  chk_drive_table: assert property (out1_a_oe && !bridge_a_regulating_n_oe && !decay_select_bit0
    && !decay_select_bit1 |-> {out1_a, out2_a} == $past({direction_in_first_a, direction_in_second_a}))
    else $error("drive state differs from direction inputs");
  chk_dir_restart: assert property (bridge_a_regulating_n_oe ##0 dir_a_moves |=> bridge_a_regulating_n_oe [*8])
    else $error("off phase not restarted");
  chk_ocp_retry: assert property (oc_q == BLANK_CYCLES + 4 |-> fault_n_oe && b_off)
    else $error("overcurrent not answered by retry");
  chk_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single pulse");
endmodule : hcc_props
bind hcc_top hcc_props #(.BLANK_CYCLES(BLANK_CYCLES)) u_props (
  .mclk(mclk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sleep_n(sleep_n),
  .bridge_en_a(bridge_en_a), .direction_in_first_a(direction_in_first_a),
  .direction_in_second_a(direction_in_second_a), .decay_select_bit0(decay_select_bit0),
  .decay_select_bit1(decay_select_bit1), .overcurrent_b(overcurrent_b), .over_temp(over_temp),
  .vm_undervoltage(vm_undervoltage), .out1_a(out1_a), .out2_a(out2_a), .out1_a_oe(out1_a_oe),
  .out2_a_oe(out2_a_oe), .out1_b_oe(out1_b_oe), .out2_b_oe(out2_b_oe),
  .bridge_a_regulating_n_oe(bridge_a_regulating_n_oe), .fault_n_oe(fault_n_oe));
`default_nettype wire

// file: sim/hcc_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module hcc_ctl_model (
  input  wire logic       mclk,
  input  wire logic [1:0] en_cmd,
  input  wire logic [3:0] dir_cmd,
  input  wire logic       fault_n_o,
  input  wire logic       fault_n_oe,
  input  wire logic       reg_a_o,
  input  wire logic       reg_a_oe,
  input  wire logic       reg_b_o,
  input  wire logic       reg_b_oe,
  output var  logic [1:0] en_q,
  output var  logic [3:0] dir_q,
  output wire logic       fault_n_i,
  output wire logic       reg_a_i,
  output wire logic       reg_b_i
);
  // enable follows the bench only; it is never chopped
  always_ff @(posedge mclk) en_q <= en_cmd;
  always_ff @(posedge mclk) dir_q <= dir_cmd;
  // pull-ups on the open-drain pins
  assign fault_n_i = fault_n_oe ? fault_n_o : 1'b1;
  assign reg_a_i   = reg_a_oe ? reg_a_o : 1'b1;
  assign reg_b_i   = reg_b_oe ? reg_b_o : 1'b1;
endmodule : hcc_ctl_model
`default_nettype wire

// file: sim/h_bridge_current_chopper_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module h_bridge_current_chopper_tb_top;
  import hcc_pkg::*;
  localparam int LIMIT = 20000;
  logic        mclk, nrst, cyc, stb, we, trip_a, oc_b, nz_a, temp, uv, sleep_n, d0, d1, ce;
  logic [7:0]  adr;
  logic [3:0]  sel, dir_cmd;
  logic [1:0]  en_cmd;
  logic [31:0] wdat, q, lf;
  int          num_errors = 0, checked = 0, cnt = 0;
  wire [1:0]   en;
  wire [3:0]   dir;
  wire [31:0]  rdat;
  wire [7:0]   tha, thb;
  wire         ack, o1a, o2a, o1ae, o2ae, o1be, o2be, fo, foe, fault_n_i, rao, raoe, rbo, rboe, rga_i, rgb_i, o1b, o2b;
  wire [4:0]   pa = {raoe, o1ae, o2ae, o1a, o2a};
  hcc_top #(.RETRY_CYCLES(50), .WAKE_CYCLES(20), .BLANK_CYCLES(3)) DUT (
    .mclk(mclk), .nrst(nrst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sleep_n(sleep_n),
    .bridge_en_a(en[0]), .bridge_en_b(en[1]), .direction_in_first_a(dir[1]), .direction_in_second_a(dir[0]),
    .direction_in_first_b(dir[3]), .direction_in_second_b(dir[2]), .decay_select_bit0(d0),
    .decay_select_bit1(d1), .trip_current_a(trip_a), .trip_current_b(1'b0), .overcurrent_a(1'b0),
    .overcurrent_b(oc_b), .near_zero_a(nz_a), .near_zero_b(nz_a), .over_temp(temp), .vm_undervoltage(uv),
    .out1_a(o1a), .out1_a_oe(o1ae), .out2_a(o2a), .out2_a_oe(o2ae), .out1_b(o1b), .out1_b_oe(o1be),
    .out2_b(o2b), .out2_b_oe(o2be), .bridge_a_regulating_n_i(rga_i), .bridge_a_regulating_n_o(rao),
    .bridge_a_regulating_n_oe(raoe), .bridge_b_regulating_n_i(rgb_i), .bridge_b_regulating_n_o(rbo),
    .bridge_b_regulating_n_oe(rboe), .fault_n_i(fault_n_i), .fault_n_o(fo), .fault_n_oe(foe),
    .threshold_set_a(tha), .threshold_set_b(thb));
  hcc_ctl_model u_ctl (.mclk(mclk), .en_cmd(en_cmd), .dir_cmd(dir_cmd), .fault_n_o(fo), .fault_n_oe(foe),
    .reg_a_o(rao), .reg_a_oe(raoe), .reg_b_o(rbo), .reg_b_oe(rboe), .en_q(en), .dir_q(dir),
    .fault_n_i(fault_n_i), .reg_a_i(rga_i), .reg_b_i(rgb_i));
  ////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt
  function automatic int off_cyc(input int k);
    int c;
    c = k * int'(KTOFF_NS_PER_KOHM) / int'(CLK_PERIOD_NS);
    return c < int'(OFF_MIN_CYC) ? int'(OFF_MIN_CYC) : (c > int'(OFF_MAX_CYC) ? int'(OFF_MAX_CYC) : c);
  endfunction : off_cyc
  task step(input int n);
    repeat (n) @(posedge mclk);
  endtask : step
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n == 50) num_errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task wake();
    int n;
    n = 0;
    do begin
      wb(1'b0, ADR_STATUS, 4'hf, 32'h0);
      n++;
    end while (q[ST_AWAKE] !== 1'b1 && n < 40);
    cmp(q[ST_AWAKE], 1'b1);
  endtask : wake
  task trip();
    @(posedge mclk);
    trip_a <= 1'b1;
    @(posedge mclk);
    trip_a <= 1'b0;
  endtask : trip
  // one chop per decay code; bridge a drives 10 throughout
  task chop(input int len);
    for (int d = 0; d < 4; d++) begin
      {d1, d0} <= d[1:0];
      step(3);
      trip();
      step(5);
      cmp(pa, d == 0 ? 5'b11100 : 5'b01101);
      if (d == 3) begin
        nz_a <= 1'b1;
        step(3);
        cmp(pa[3:2], 2'b00);
        nz_a <= 1'b0;
      end
      step(len - 18);
      cmp(pa[4], d != 3);
      step(25);
      cmp(pa, 5'b01110);
    end
  endtask : chop
  task stop_test();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cnt <= cnt + 1;
    if (cnt == LIMIT) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    {nrst, cyc, stb, we, trip_a, oc_b, nz_a, temp, uv, d0, d1} = '0;
    {adr, sel, wdat, en_cmd, dir_cmd} = '0;
    {sleep_n, ce} = 2'b11;
    lf = 32'h31473ae5;
    step(8);
    nrst <= 1'b1;
    wb(1'b0, ADR_CFG, 4'hf, 32'h0);
    cmp(q, {16'h0, CFG_KOHM_RST, 7'h00, CFG_INT_RST});
    wb(1'b0, ADR_THR_A, 4'hf, 32'h0);
    cmp(q, {24'h0, THR_RST});
    wb(1'b0, 8'h10, 4'hf, 32'h0);
    cmp(q, 32'h0);
    wake();
    cmp(pa[3:2], 2'b00);
    lf = nxt(lf);
    wb(1'b1, ADR_THR_B, 4'h1, lf);
    cmp({thb, tha}, {lf[7:0], THR_RST});
    en_cmd <= 2'b11;
    for (int i = 0; i < 12; i++) begin
      lf = nxt(lf);
      dir_cmd[1:0] <= lf[1:0];
      step(4);
      cmp(pa, {3'b011, lf[1:0]});
    end
    dir_cmd[1:0] <= 2'b10;
    step(4);
    trip();
    step(OFF_INT_CYC / 2);
    dir_cmd[1:0] <= 2'b11;
    step(OFF_INT_CYC / 2 + 5);
    cmp(pa, 5'b11100);
    step(OFF_INT_CYC / 2 + 5);
    cmp(pa, 5'b01111);
    dir_cmd[1:0] <= 2'b10;
    chop(OFF_INT_CYC);
    wb(1'b1, ADR_CFG, 4'h3, 32'h00000f00);
    chop(off_cyc(15));
    dir_cmd[3:2] <= 2'b01;
    oc_b <= 1'b1;
    step(2);
    oc_b <= 1'b0;
    step(5);
    cmp({fault_n_i, o1be, o2be, o1b, o2b}, 5'b11101);
    oc_b <= 1'b1;
    step(8);
    oc_b <= 1'b0;
    step(2);
    cmp({fault_n_i, o1be, o2be, pa}, 8'b000_01110);
    step(30);
    ce <= 1'b0;
    step(40);
    cmp({fault_n_i, o1be, o2be}, 3'b000);
    ce <= 1'b1;
    step(30);
    cmp({fault_n_i, o1be, o2be, o1b, o2b}, 5'b11101);
    for (int i = 1; i < 3; i++) begin
      {uv, temp} <= i[1:0];
      step(4);
      cmp({fault_n_i, pa[3:2]}, 3'b000);
      {uv, temp} <= 2'b00;
      step(4);
      cmp({fault_n_i, pa[3:2]}, 3'b111);
    end
    sleep_n <= 1'b0;
    step(3);
    cmp({pa[3:2], o1be, o2be}, 4'h0);
    sleep_n <= 1'b1;
    wake();
    step(2);
    cmp(pa, 5'b01110);
    stop_test();
  end
endmodule : h_bridge_current_chopper_tb_top
`default_nettype wire
